//--- hdl/gtc_gated_timer.sv
// Gated 16-bit timer with gate toggle, single pulse, flags, capture and compare, APB slave
`timescale 1ns/100ps
module gtc_gated_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_tick,
   input wire logic gate_pin,
   input wire logic timer0_overflow,
   input wire logic comparator_a_output,
   input wire logic comparator_b_output,
   input wire logic capture_event,
   input wire logic sleep_mode,
   output gtc_pkg::gtc_event_out_type events,
   output logic low_freq_osc_run
);
   // ==========================================================
   // Declarations
   logic timer_on, sync_disable, low_freq_osc_enable;
   logic [1:0] clock_source_select;
   gtc_pkg::gtc_gate_cfg_type gate_cfg;
   gtc_pkg::gtc_enable_type en;
   logic gate_go_done;
   logic [15:0] count;
   logic [15:0] capture_compare;
   logic overflow_flag, gate_event_flag, compare_flag;
   logic pin_meta, pin_sync, cmpa_meta, cmpa_sync, cmpb_meta, cmpb_sync;
   logic cmpa_held, cmpb_held;
   logic gate_src, gate_active, gate_active_prev;
   logic toggle_ff, toggled, toggled_prev;
   logic pulse_open;
   logic gate_value_status, next_gate_value;
   logic count_enable, count_run, count_step, wrap;
   logic match, trigger_clear;
   logic wr, rd_setup, mapped;
   logic wr_tc, wr_gc, wr_cl, wr_ch, wr_pl, wr_ph, wr_fl, wr_en;
   logic [15:0] next_count;
   logic [31:0] rd_value;

   // Address decode shared by read and write paths
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == gtc_pkg::ADDR_TIMER_CONTROL) || (a == gtc_pkg::ADDR_GATE_CONTROL)
         || (a == gtc_pkg::ADDR_COUNT_LOW) || (a == gtc_pkg::ADDR_COUNT_HIGH)
         || (a == gtc_pkg::ADDR_CCP_LOW) || (a == gtc_pkg::ADDR_CCP_HIGH)
         || (a == gtc_pkg::ADDR_FLAGS) || (a == gtc_pkg::ADDR_ENABLES);
   endfunction

   // ==========================================================
   // APB slave, zero wait states
   assign pready = 1'b1;
   assign mapped = is_mapped(paddr);
   assign pslverr = psel && penable && !mapped; // Unmapped address errors
   assign wr = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_tc = wr && (paddr == gtc_pkg::ADDR_TIMER_CONTROL);
   assign wr_gc = wr && (paddr == gtc_pkg::ADDR_GATE_CONTROL);
   assign wr_cl = wr && (paddr == gtc_pkg::ADDR_COUNT_LOW);
   assign wr_ch = wr && (paddr == gtc_pkg::ADDR_COUNT_HIGH);
   assign wr_pl = wr && (paddr == gtc_pkg::ADDR_CCP_LOW);
   assign wr_ph = wr && (paddr == gtc_pkg::ADDR_CCP_HIGH);
   assign wr_fl = wr && (paddr == gtc_pkg::ADDR_FLAGS);
   assign wr_en = wr && (paddr == gtc_pkg::ADDR_ENABLES);

   // Read mux, captured in setup so prdata is a flip-flop
   always_comb begin
      rd_value = 32'h0000_0000;
      case (paddr)
         gtc_pkg::ADDR_TIMER_CONTROL: begin
            rd_value[gtc_pkg::TC_ON] = timer_on;
            rd_value[gtc_pkg::TC_SYNC_DIS] = sync_disable;
            rd_value[gtc_pkg::TC_OSC_EN] = low_freq_osc_enable;
            rd_value[gtc_pkg::TC_CS_HI:gtc_pkg::TC_CS_LO] = clock_source_select;
         end
         gtc_pkg::ADDR_GATE_CONTROL: begin
            rd_value[gtc_pkg::GC_EN] = gate_cfg.gate_enable;
            rd_value[gtc_pkg::GC_POL] = gate_cfg.gate_polarity;
            rd_value[gtc_pkg::GC_TM] = gate_cfg.gate_toggle_mode;
            rd_value[gtc_pkg::GC_SPM] = gate_cfg.gate_single_pulse_mode;
            rd_value[gtc_pkg::GC_GO] = gate_go_done;
            rd_value[gtc_pkg::GC_VAL] = gate_value_status; // Live level
            rd_value[gtc_pkg::GC_SEL_HI:gtc_pkg::GC_SEL_LO] = gate_cfg.gate_source_select;
         end
         gtc_pkg::ADDR_COUNT_LOW: rd_value[7:0] = count[7:0];
         gtc_pkg::ADDR_COUNT_HIGH: rd_value[7:0] = count[15:8];
         gtc_pkg::ADDR_CCP_LOW: rd_value[7:0] = capture_compare[7:0];
         gtc_pkg::ADDR_CCP_HIGH: rd_value[7:0] = capture_compare[15:8];
         gtc_pkg::ADDR_FLAGS: begin
            rd_value[gtc_pkg::FL_OVF] = overflow_flag;
            rd_value[gtc_pkg::FL_GATE] = gate_event_flag;
            rd_value[gtc_pkg::FL_CMP] = compare_flag;
         end
         gtc_pkg::ADDR_ENABLES: rd_value[7:0] = en;
         default: rd_value = 32'h0000_0000;
      endcase
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_value;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_on <= 1'b0;
         sync_disable <= 1'b0;
         low_freq_osc_enable <= 1'b0;
         clock_source_select <= 2'h0;
      end else if (wr_tc) begin
         timer_on <= pwdata[gtc_pkg::TC_ON];
         sync_disable <= pwdata[gtc_pkg::TC_SYNC_DIS];
         low_freq_osc_enable <= pwdata[gtc_pkg::TC_OSC_EN];
         clock_source_select <= pwdata[gtc_pkg::TC_CS_HI:gtc_pkg::TC_CS_LO];
      end
   end

   // Gate configuration; toggle and polarity written together are the caller's risk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_cfg <= '0;
      end else if (wr_gc) begin
         gate_cfg.gate_enable <= pwdata[gtc_pkg::GC_EN];
         gate_cfg.gate_polarity <= pwdata[gtc_pkg::GC_POL];
         gate_cfg.gate_toggle_mode <= pwdata[gtc_pkg::GC_TM];
         gate_cfg.gate_single_pulse_mode <= pwdata[gtc_pkg::GC_SPM];
         gate_cfg.gate_source_select <= pwdata[gtc_pkg::GC_SEL_HI:gtc_pkg::GC_SEL_LO];
      end
   end

   // Interrupt enables and capture/compare modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en <= '0;
      end else if (wr_en) begin
         en <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Input synchronisers, two flops each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         cmpa_meta <= 1'b0;
         cmpa_sync <= 1'b0;
         cmpb_meta <= 1'b0;
         cmpb_sync <= 1'b0;
      end else begin
         pin_meta <= gate_pin;
         pin_sync <= pin_meta;
         cmpa_meta <= comparator_a_output;
         cmpa_sync <= cmpa_meta;
         cmpb_meta <= comparator_b_output;
         cmpb_sync <= cmpb_meta;
      end
   end

   // Comparator copies aligned to the timer tick when sync is chosen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmpa_held <= 1'b0;
         cmpb_held <= 1'b0;
      end else if (count_tick) begin
         cmpa_held <= cmpa_sync;
         cmpb_held <= cmpb_sync;
      end
   end

   // ==========================================================
   // Gate source select and polarity
   always_comb begin
      case (gate_cfg.gate_source_select)
         gtc_pkg::SRC_PIN: gate_src = pin_sync;
         gtc_pkg::SRC_TIMER0: gate_src = timer0_overflow;
         gtc_pkg::SRC_COMP_A: gate_src = en.comparator_sync ? cmpa_held : cmpa_sync;
         gtc_pkg::SRC_COMP_B: gate_src = en.comparator_sync ? cmpb_held : cmpb_sync;
         default: gate_src = pin_sync;
      endcase
   end
   // Active when source level equals polarity
   assign gate_active = gate_cfg.gate_polarity ? gate_src : !gate_src;

   // Toggle flip-flop on each incrementing gate edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_active_prev <= 1'b0;
         toggle_ff <= 1'b0;
      end else begin
         gate_active_prev <= gate_active;
         if (!gate_cfg.gate_toggle_mode || !timer_on) begin
            toggle_ff <= 1'b0; // Held clear so the measured edge is known
         end else if (gate_active && !gate_active_prev) begin
            toggle_ff <= !toggle_ff; // One full source period per high phase
         end
      end
   end
   assign toggled = gate_cfg.gate_toggle_mode ? toggle_ff : gate_active;

   // ==========================================================
   // Single pulse window; toggle feeds it for one-period capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggled_prev <= 1'b0;
         pulse_open <= 1'b0;
      end else begin
         toggled_prev <= toggled;
         if (!gate_cfg.gate_single_pulse_mode || !gate_go_done) begin
            pulse_open <= 1'b0; // Further gate events ignored
         end else if (toggled && !toggled_prev) begin
            pulse_open <= 1'b1; // Opens at next incrementing edge
         end else if (!toggled && toggled_prev) begin
            pulse_open <= 1'b0;
         end
      end
   end

   // Gate value seen by counter and status
   always_comb begin
      if (gate_cfg.gate_single_pulse_mode) begin
         next_gate_value = gate_go_done && toggled && (pulse_open || !toggled_prev);
      end else begin
         next_gate_value = toggled;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_value_status <= 1'b0;
      end else begin
         gate_value_status <= next_gate_value; // Tracked regardless of gate enable
      end
   end

   // Go/done; a software write in the same cycle beats the hardware clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_go_done <= 1'b0;
      end else if (wr_gc) begin
         gate_go_done <= pwdata[gtc_pkg::GC_GO];
      end else if (gate_cfg.gate_single_pulse_mode && pulse_open && !toggled) begin
         gate_go_done <= 1'b0; // Cleared at trailing edge
      end
   end

   // ==========================================================
   // Count enable and stepping
   // Sleep counting only when unsynchronised
   assign count_run = timer_on && (!sleep_mode || sync_disable);
   assign count_enable = count_run && (!gate_cfg.gate_enable || gate_value_status);
   assign count_step = count_tick && count_enable;
   assign wrap = count_step && (count == gtc_pkg::COUNT_MAX);
   assign match = en.compare_mode && (count == capture_compare);
   assign trigger_clear = match && en.compare_trigger_enable && count_tick;

   // Next count; byte writes beat the trigger clear
   always_comb begin
      next_count = count;
      if (trigger_clear) begin
         next_count = gtc_pkg::COUNT_ZERO; // Compare register acts as period
      end else if (count_step) begin
         next_count = count + gtc_pkg::COUNT_ONE; // Wraps to zero
      end
      if (wr_cl) begin
         next_count[7:0] = pwdata[7:0];
      end
      if (wr_ch) begin
         next_count[15:8] = pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= gtc_pkg::COUNT_ZERO;
      end else begin
         count <= next_count;
      end
   end

   // Capture/compare register; hardware capture wins over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_compare <= gtc_pkg::COUNT_ZERO;
      end else if (en.capture_mode && capture_event) begin
         capture_compare <= count;
      end else begin
         if (wr_pl) begin
            capture_compare[7:0] <= pwdata[7:0];
         end
         if (wr_ph) begin
            capture_compare[15:8] <= pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // Sticky flags, write one to clear, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
         gate_event_flag <= 1'b0;
         compare_flag <= 1'b0;
      end else begin
         // Trigger clear is not a wrap, so no overflow flag
         overflow_flag <= (overflow_flag && !(wr_fl && pwdata[gtc_pkg::FL_OVF]))
            || (wrap && !trigger_clear);
         // Falling gate value, gate enable not consulted
         gate_event_flag <= (gate_event_flag && !(wr_fl && pwdata[gtc_pkg::FL_GATE]))
            || (gate_value_status && !next_gate_value);
         compare_flag <= (compare_flag && !(wr_fl && pwdata[gtc_pkg::FL_CMP]))
            || (match && count_tick);
      end
   end

   // ==========================================================
   // Interrupt requests, wake and compare event; one process owns the whole struct
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         events <= '0;
      end else begin
         events.compare_event <= match && count_tick; // One cycle per matching tick
         events.overflow_irq <= overflow_flag && timer_on && en.overflow_irq_enable
            && en.peripheral_irq_enable && en.global_irq_enable;
         events.gate_event_irq <= gate_event_flag && en.gate_event_irq_enable
            && en.peripheral_irq_enable && en.global_irq_enable;
         // Wake needs no global enable; that only decides on the service call
         events.wake_request <= sleep_mode && overflow_flag && timer_on && sync_disable
            && en.overflow_irq_enable && en.peripheral_irq_enable;
      end
   end

   // Oscillator run ignores sleep and sync disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_freq_osc_run <= 1'b0;
      end else begin
         low_freq_osc_run <= low_freq_osc_enable;
      end
   end
endmodule

//--- hdl/gtc_pkg.sv
// Package of register map, field positions and types for the gated timer control block
package gtc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_GATE_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_CCP_LOW = 8'h10;
   localparam logic [7:0] ADDR_CCP_HIGH = 8'h14;
   localparam logic [7:0] ADDR_FLAGS = 8'h18;
   localparam logic [7:0] ADDR_ENABLES = 8'h1C;
   // ==========================================================
   // Timer control field positions
   localparam int TC_ON = 0;
   localparam int TC_SYNC_DIS = 2;
   localparam int TC_OSC_EN = 3;
   localparam int TC_CS_LO = 6;
   localparam int TC_CS_HI = 7;
   // Gate control field positions
   localparam int GC_SEL_LO = 0;
   localparam int GC_SEL_HI = 1;
   localparam int GC_VAL = 2;
   localparam int GC_GO = 3;
   localparam int GC_SPM = 4;
   localparam int GC_TM = 5;
   localparam int GC_POL = 6;
   localparam int GC_EN = 7;
   // Flag positions, write one to clear
   localparam int FL_OVF = 0;
   localparam int FL_GATE = 1;
   localparam int FL_CMP = 2;
   // Enable register positions
   localparam int EN_OVF_IE = 0;
   localparam int EN_GATE_IE = 1;
   localparam int EN_PERIPH_IE = 2;
   localparam int EN_GLOBAL_IE = 3;
   localparam int EN_CAPTURE = 4;
   localparam int EN_COMPARE = 5;
   localparam int EN_TRIGGER = 6;
   localparam int EN_COMP_SYNC = 7;
   // ==========================================================
   // Gate source codes
   localparam logic [1:0] SRC_PIN = 2'h0;
   localparam logic [1:0] SRC_TIMER0 = 2'h1;
   localparam logic [1:0] SRC_COMP_A = 2'h2;
   localparam logic [1:0] SRC_COMP_B = 2'h3;
   // Reset values and count limits
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   // ==========================================================
   // Types
   typedef struct packed {
      logic gate_enable;
      logic gate_polarity;
      logic gate_toggle_mode;
      logic gate_single_pulse_mode;
      logic [1:0] gate_source_select;
   } gtc_gate_cfg_type;
   typedef struct packed {
      logic comparator_sync;
      logic compare_trigger_enable;
      logic compare_mode;
      logic capture_mode;
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic gate_event_irq_enable;
      logic overflow_irq_enable;
   } gtc_enable_type;
   typedef struct packed {
      logic overflow_irq;
      logic gate_event_irq;
      logic wake_request;
      logic compare_event;
   } gtc_event_out_type;
endpackage

//--- testbench/gtc_gate_model.sv
// Far-side model: gate pin square wave and static gate source levels
`timescale 1ns/100ps
module gtc_gate_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] levels,
   input wire logic [7:0] half,
   output logic gate_pin,
   output logic timer0_overflow,
   output logic comparator_a_output,
   output logic comparator_b_output
);
   logic [7:0] phase;
   logic square;
   // Square wave on the pin while half is nonzero, restarts low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 8'h00;
         square <= 1'h0;
      end else if (half == 8'h00) begin
         phase <= 8'h00;
         square <= 1'h0;
      end else if (phase == half - 8'h01) begin
         phase <= 8'h00;
         square <= !square;
      end else begin
         phase <= phase + 8'h01;
      end
   end
   // Static levels otherwise; the overflow source is held as a level
   assign gate_pin = (half != 8'h00) ? square : levels[0];
   assign timer0_overflow = levels[1];
   assign comparator_a_output = levels[2];
   assign comparator_b_output = levels[3];
endmodule

//--- testbench/gtc_gated_timer_properties.sv
// Concurrent checks on the gated timer ports, with the bind that attaches them
`timescale 1ns/100ps
module gtc_gated_timer_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic count_tick,
   input wire logic sleep_mode,
   input wire gtc_pkg::gtc_event_out_type events,
   input wire logic low_freq_osc_run
);
   logic [7:0] tc_sh;
   logic [7:0] en_sh;
   logic wr_en;
   // ==========================================================
   // Shadows of control bytes, taken at the same edge as the write
   assign wr_en = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_sh <= 8'h00;
         en_sh <= 8'h00;
      end else if (wr_en && paddr == gtc_pkg::ADDR_TIMER_CONTROL) begin
         tc_sh <= pwdata[7:0];
      end else if (wr_en && paddr == gtc_pkg::ADDR_ENABLES) begin
         en_sh <= pwdata[7:0];
      end
   end
   // Interrupt outputs lag their causes by one edge, hence the past values
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_off;
      !tc_sh[0] [*2];
   endsequence
   property p_ovf_irq; events.overflow_irq |-> $past(tc_sh[0] && en_sh[0] && (&en_sh[3:2])); endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq without enables");
   property p_off; s_off |-> !events.overflow_irq; endproperty
   a_off: assert property (p_off) else $error("overflow irq with timer off");
   property p_global; !en_sh[3] [*2] |-> !(events.overflow_irq || events.gate_event_irq); endproperty
   a_global: assert property (p_global) else $error("irq with global enable off");
   property p_gate_irq; events.gate_event_irq |-> $past(&en_sh[3:1]); endproperty
   a_gate_irq: assert property (p_gate_irq) else $error("gate irq without enables");
   property p_gate_off;
      wr_en && paddr == gtc_pkg::ADDR_ENABLES && !pwdata[1] |=> ##1 !events.gate_event_irq;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate irq stays after disable");
   property p_cmp; events.compare_event |-> $past(count_tick && en_sh[5]); endproperty
   a_cmp: assert property (p_cmp) else $error("compare event without tick");
   property p_osc; low_freq_osc_run == $past(tc_sh[3]); endproperty
   a_osc: assert property (p_osc) else $error("oscillator run differs");
   property p_wake; events.wake_request |-> $past(sleep_mode && tc_sh[0] && tc_sh[2] && en_sh[0]); endproperty
   a_wake: assert property (p_wake) else $error("wake without setup");
   c_ovf: cover property (events.overflow_irq);
   c_gate: cover property (events.gate_event_irq);
   c_cmp: cover property (events.compare_event);
   c_wake: cover property (events.wake_request);
endmodule
bind gtc_gated_timer gtc_gated_timer_properties i_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .count_tick(count_tick), .sleep_mode(sleep_mode),
   .events(events), .low_freq_osc_run(low_freq_osc_run)
);

//--- testbench/gtc_gated_timer_test.sv
// Self-checking bench for the gated timer control block
`timescale 1ns/100ps
module gtc_gated_timer_test;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] rst;
      logic [7:0] wdat;
      logic [7:0] exp;
      logic err;
   } gtc_row_type;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
   logic sleep_mode = 1'h0, tick_en = 1'h0, cap_req = 1'h0;
   logic gate_pin, timer0_overflow, comparator_a_output, comparator_b_output, low_freq_osc_run;
   logic [7:0] paddr = 8'h00, half = 8'h00, rd, keep;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] levels = 4'h0;
   gtc_pkg::gtc_event_out_type events;
   int mismatches = 0, tests_run = 0, cycles = 0;
   gtc_row_type rows [7];
   gtc_gated_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_tick(tick_en), .gate_pin(gate_pin),
      .timer0_overflow(timer0_overflow), .comparator_a_output(comparator_a_output),
      .comparator_b_output(comparator_b_output), .capture_event(cap_req),
      .sleep_mode(sleep_mode), .events(events), .low_freq_osc_run(low_freq_osc_run));
   gtc_gate_model i_model (.pclk(pclk), .presetn(presetn), .levels(levels), .half(half),
      .gate_pin(gate_pin), .timer0_overflow(timer0_overflow),
      .comparator_a_output(comparator_a_output), .comparator_b_output(comparator_b_output));
   initial forever #5 pclk = ~pclk;
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   // Request held until pready is seen high, released only after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdr(input logic [7:0] a);
      apb(1'h0, a, 8'h00);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      rows = '{'{gtc_pkg::ADDR_TIMER_CONTROL, 8'h00, 8'hC5, 8'hC5, 1'h0},
         '{gtc_pkg::ADDR_GATE_CONTROL, 8'h04, 8'hF3, 8'hF3, 1'h0},
         '{gtc_pkg::ADDR_COUNT_LOW, 8'h00, 8'h5A, 8'h5A, 1'h0},
         '{gtc_pkg::ADDR_CCP_HIGH, 8'h00, 8'hC3, 8'hC3, 1'h0},
         '{gtc_pkg::ADDR_FLAGS, 8'h02, 8'h07, 8'h00, 1'h0},
         '{gtc_pkg::ADDR_ENABLES, 8'h00, 8'h0F, 8'h0F, 1'h0},
         '{8'h20, 8'h00, 8'h77, 8'h00, 1'h1}};
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      // Value before, write, read back; gate config write drops live gate value, flag set
      foreach (rows[i]) begin
         rdr(rows[i].addr);
         chk(rd, rows[i].rst);
         wr(rows[i].addr, rows[i].wdat);
         rdr(rows[i].addr);
         chk(rd, rows[i].exp);
         chk(er, rows[i].err);
      end
      wr(gtc_pkg::ADDR_GATE_CONTROL, 8'h00);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h08);
      sleep_mode <= 1'h1;
      repeat (3) @(posedge pclk);
      chk(low_freq_osc_run, 1'h1);
      // Sleep, wrap and wake; flag cleared before the enables
      wr(gtc_pkg::ADDR_COUNT_LOW, 8'hFE);
      wr(gtc_pkg::ADDR_COUNT_HIGH, 8'hFF);
      wr(gtc_pkg::ADDR_FLAGS, 8'hFF);
      wr(gtc_pkg::ADDR_ENABLES, 8'h0D);
      tick_en <= 1'h1;
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h01);
      repeat (10) @(posedge pclk);
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      chk(rd, 8'hFE);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h0D);
      repeat (10) @(posedge pclk);
      rdr(gtc_pkg::ADDR_FLAGS);
      chk(rd[gtc_pkg::FL_OVF], 1'h1);
      chk(events.wake_request, 1'h1);
      chk(events.overflow_irq, 1'h1);
      rdr(gtc_pkg::ADDR_COUNT_HIGH);
      chk(rd, 8'h00);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
      wr(gtc_pkg::ADDR_FLAGS, 8'h01);
      sleep_mode <= 1'h0;
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      keep = rd;
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      chk(rd, keep);
      chk(events.overflow_irq, 1'h0);
      // Gated counting, live status, falling edge with gating off
      wr(gtc_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(gtc_pkg::ADDR_GATE_CONTROL, 8'hC0);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h01);
      repeat (10) @(posedge pclk);
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      chk(rd, 8'h00);
      levels <= 4'h1;
      repeat (10) @(posedge pclk);
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      chk(rd != 8'h00, 1'h1);
      wr(gtc_pkg::ADDR_FLAGS, 8'hFF);
      wr(gtc_pkg::ADDR_ENABLES, 8'h0E);
      wr(gtc_pkg::ADDR_GATE_CONTROL, 8'h40);
      rdr(gtc_pkg::ADDR_GATE_CONTROL);
      chk(rd[gtc_pkg::GC_VAL], 1'h1);
      levels <= 4'h0;
      repeat (8) @(posedge pclk);
      rdr(gtc_pkg::ADDR_FLAGS);
      chk(rd[gtc_pkg::FL_GATE], 1'h1);
      chk(events.gate_event_irq, 1'h1);
      // Every source code, passed through and resampled
      for (int k = 0; k < 8; k++) begin
         wr(gtc_pkg::ADDR_ENABLES, {k[2], 7'h00});
         wr(gtc_pkg::ADDR_GATE_CONTROL, {6'h10, k[1:0]});
         levels <= 4'h1 << k[1:0];
         repeat (6) @(posedge pclk);
         rdr(gtc_pkg::ADDR_GATE_CONTROL);
         chk(rd[gtc_pkg::GC_VAL], 1'h1);
         levels <= ~(4'h1 << k[1:0]);
         repeat (6) @(posedge pclk);
         rdr(gtc_pkg::ADDR_GATE_CONTROL);
         chk(rd[gtc_pkg::GC_VAL], 1'h0);
      end
      // Single pulse with toggle: one full period of 20 ticks, then shut
      levels <= 4'h0;
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
      wr(gtc_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(gtc_pkg::ADDR_COUNT_HIGH, 8'h00);
      half <= 8'h0A;
      wr(gtc_pkg::ADDR_GATE_CONTROL, 8'hF0);
      wr(gtc_pkg::ADDR_GATE_CONTROL, 8'hF8);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h01);
      do rdr(gtc_pkg::ADDR_GATE_CONTROL); while (rd[gtc_pkg::GC_GO] !== 1'h0);
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      chk(rd, 8'h14);
      repeat (60) @(posedge pclk);
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      chk(rd, 8'h14);
      wr(gtc_pkg::ADDR_GATE_CONTROL, 8'h00);
      half <= 8'h00;
      // Compare trigger as period, synchronised counting, then capture
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
      wr(gtc_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(gtc_pkg::ADDR_CCP_LOW, 8'h10);
      wr(gtc_pkg::ADDR_CCP_HIGH, 8'h00);
      wr(gtc_pkg::ADDR_FLAGS, 8'hFF);
      wr(gtc_pkg::ADDR_ENABLES, 8'h60);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h01);
      repeat (100) @(posedge pclk);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rdr(gtc_pkg::ADDR_FLAGS);
      chk(rd[2:0], 3'h4);
      rdr(gtc_pkg::ADDR_COUNT_LOW);
      chk(rd <= 8'h10, 1'h1);
      wr(gtc_pkg::ADDR_ENABLES, 8'h10);
      wr(gtc_pkg::ADDR_COUNT_LOW, 8'h33);
      cap_req <= 1'h1;
      @(posedge pclk);
      cap_req <= 1'h0;
      rdr(gtc_pkg::ADDR_CCP_LOW);
      chk(rd, 8'h33);
      // Mid-run reset clears the capture register again
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      rdr(gtc_pkg::ADDR_CCP_LOW);
      chk(rd, 8'h00);
      conclude();
   end
endmodule
